// ===== rtl/gpb_pkg.sv
// Shared constants and types for the GPIO pin control bank
package gpb_pkg;
  localparam int          NPIN       = 24;
  // Byte address of the high byte of each group; middle and low follow
  localparam logic [7:0]  OFS_SET    = 8'h83;
  localparam logic [7:0]  OFS_CLR    = 8'h86;
  localparam logic [7:0]  OFS_DIR    = 8'h89;
  localparam logic [7:0]  OFS_EDGE   = 8'h8C;
  localparam logic [7:0]  OFS_RISE   = 8'h8F;
  localparam logic [7:0]  OFS_FALL   = 8'h92;
  localparam logic [7:0]  OFS_PU     = 8'h95;
  localparam logic [7:0]  OFS_PD     = 8'h98;
  localparam logic [7:0]  OFS_AFU    = 8'h9B;
  localparam logic [7:0]  OFS_AFL    = 8'h9E;
  localparam logic [7:0]  OFS_MON    = 8'hA2;
  // Byte lane masks for high, middle and low byte of a group
  localparam logic [23:0] LANE_HIGH  = 24'hFF0000;
  localparam logic [23:0] LANE_MID   = 24'h00FF00;
  localparam logic [23:0] LANE_LOW   = 24'h0000FF;
  localparam logic [23:0] RST_ZERO   = 24'h000000;
  localparam logic [1:0]  FN_PRIMARY = 2'h0;
  localparam logic [3:0]  BITS_BYTE  = 4'h8;
  // Slave address on the serial bus; value is arbitrary
  localparam logic [6:0]  DEV_ADDR   = 7'h2A;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK, ST_WDAT, ST_WACK, ST_RDAT, ST_MACK
  } gpb_i2c_e;
endpackage : gpb_pkg

// ===== rtl/gpb_pin_if.sv
// Synchronised pin levels and edge pulses between sampler and core
`timescale 1ns/1ps
interface gpb_pin_if;
  logic [23:0] lvl;
  logic [23:0] rise;
  logic [23:0] fall;
  modport sync (output lvl, output rise, output fall);
  modport core (input lvl, input rise, input fall);
endinterface : gpb_pin_if

// ===== rtl/gpb_pin_sync.sv
// Three-stage pin sampler with agreed-level edge detection
`timescale 1ns/1ps
module gpb_pin_sync
  import gpb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [23:0] gpio_i,
  gpb_pin_if.sync          pin
);
  logic [23:0] s1_q;
  logic [23:0] s2_q;
  logic [23:0] s3_q;
  logic [23:0] lvl_q;
  logic [23:0] rise_q;
  logic [23:0] fall_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s1_q <= RST_ZERO;
      s2_q <= RST_ZERO;
      s3_q <= RST_ZERO;
    end else begin
      s1_q <= gpio_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NPIN; i++) begin : g_pin
      logic lvl_d;
      assign lvl_d = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          lvl_q[i]  <= 1'b0;
          rise_q[i] <= 1'b0;
          fall_q[i] <= 1'b0;
        end else begin
          lvl_q[i]  <= lvl_d;
          rise_q[i] <= lvl_d & ~lvl_q[i];
          fall_q[i] <= ~lvl_d & lvl_q[i];
        end
      end
    end
  endgenerate

  assign pin.lvl  = lvl_q;
  assign pin.rise = rise_q;
  assign pin.fall = fall_q;

  a_sync_agree: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (s2_q[0] == s3_q[0]) && (s3_q[0] != lvl_q[0]) |=> lvl_q[0] == $past(s3_q[0]) && (rise_q[0] | fall_q[0]))
    else $error("pin level did not follow agreed samples");
endmodule : gpb_pin_sync

// ===== rtl/gpb_top.sv
// GPIO pin control bank with its serial register port
`timescale 1ns/1ps
module gpb_top
  import gpb_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  input  wire logic [23:0]      gpio_i,
  output logic      [23:0]      gpio_o,
  output logic      [23:0]      gpio_oe,
  output logic      [23:0]      pullup_en,
  output logic      [23:0]      pulldown_en,
  output logic      [47:0]      func_sel,
  output logic      [23:0]      edge_status,
  input  wire logic [2:0][23:0] alt_o,
  input  wire logic [2:0][23:0] alt_oe
);
  gpb_pin_if pin_if ();
  gpb_pin_sync u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .gpio_i  (gpio_i),
    .pin     (pin_if)
  );
  // Byte lane of a group that an address hits
  function automatic logic [23:0] lane(input logic [7:0] a, input logic [7:0] base);
    logic [23:0] m;
    m = RST_ZERO;
    if (a == base) begin
      m = LANE_HIGH;
    end else if (a == base + 8'h01) begin
      m = LANE_MID;
    end else if (a == base + 8'h02) begin
      m = LANE_LOW;
    end
    return m;
  endfunction : lane
  function automatic logic [7:0] pick(input logic [23:0] v, input logic [7:0] a, input logic [7:0] base);
    logic [23:0] t;
    t = v & lane(a, base);
    return t[23:16] | t[15:8] | t[7:0];
  endfunction : pick
  // Serial bus sampling
  logic [2:0] scl_sh_q;
  logic [2:0] sda_sh_q;
  logic       scl_q;
  logic       sda_q;
  logic       scl_p_q;
  logic       sda_p_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      scl_sh_q <= 3'h7;
      sda_sh_q <= 3'h7;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
    end else begin
      scl_sh_q <= {scl_sh_q[1:0], scl_i};
      sda_sh_q <= {sda_sh_q[1:0], sda_i};
      if (scl_sh_q[1] == scl_sh_q[2]) begin
        scl_q <= scl_sh_q[2];
      end
      if (sda_sh_q[1] == sda_sh_q[2]) begin
        sda_q <= sda_sh_q[2];
      end
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise  = scl_q & ~scl_p_q;
  assign scl_fall  = ~scl_q & scl_p_q;
  assign bus_start = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign bus_stop  = scl_q & scl_p_q & ~sda_p_q & sda_q;
  // Register state
  logic [23:0] lvl_q;
  logic [23:0] dir_q;
  logic [23:0] edge_q;
  logic [23:0] rise_q;
  logic [23:0] fall_q;
  logic [23:0] pu_q;
  logic [23:0] pd_q;
  logic [23:0] afu_q;
  logic [23:0] afl_q;
  logic        wr_q;
  logic [7:0]  wa_q;
  logic [7:0]  wd_q;
  logic [7:0]  ptr_q;
  logic [7:0]  rd_byte;
  gpb_i2c_e    st_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic        rw_q;
  logic        sda_oe_q;
  // Monitor bytes have no write path; set and clear read as zero
  assign rd_byte = pick(pin_if.lvl, ptr_q, OFS_MON) | pick(dir_q, ptr_q, OFS_DIR)
                 | pick(edge_q, ptr_q, OFS_EDGE) | pick(rise_q, ptr_q, OFS_RISE)
                 | pick(fall_q, ptr_q, OFS_FALL) | pick(pu_q, ptr_q, OFS_PU)
                 | pick(pd_q, ptr_q, OFS_PD) | pick(afu_q, ptr_q, OFS_AFU)
                 | pick(afl_q, ptr_q, OFS_AFL);
  // Byte-level slave: address, register pointer, then auto-incrementing data
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_q     <= ST_IDLE;
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      rw_q     <= 1'b0;
      ptr_q    <= 8'h00;
      sda_oe_q <= 1'b0;
      wr_q     <= 1'b0;
      wa_q     <= 8'h00;
      wd_q     <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (bus_stop) begin
        st_q     <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else if (bus_start) begin
        st_q     <= ST_ADDR;
        bit_q    <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
        unique case (st_q)
          ST_ADDR, ST_REG, ST_WDAT: begin
            sh_q  <= {sh_q[6:0], sda_q};
            bit_q <= bit_q + 4'h1;
          end
          ST_MACK: begin
            if (sda_q) begin
              st_q <= ST_IDLE;
            end else begin
              ptr_q <= ptr_q + 8'h01;
            end
          end
          ST_IDLE, ST_AACK, ST_RACK, ST_WACK, ST_RDAT: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (st_q)
          ST_ADDR: begin
            if (bit_q == BITS_BYTE) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                sda_oe_q <= 1'b1;
                rw_q     <= sh_q[0];
                st_q     <= ST_AACK;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (rw_q) begin
              sh_q     <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
              bit_q    <= 4'h1;
              st_q     <= ST_RDAT;
            end else begin
              sda_oe_q <= 1'b0;
              bit_q    <= 4'h0;
              st_q     <= ST_REG;
            end
          end
          ST_REG: begin
            if (bit_q == BITS_BYTE) begin
              ptr_q    <= sh_q;
              sda_oe_q <= 1'b1;
              st_q     <= ST_RACK;
            end
          end
          ST_RACK, ST_WACK: begin
            sda_oe_q <= 1'b0;
            bit_q    <= 4'h0;
            st_q     <= ST_WDAT;
          end
          ST_WDAT: begin
            if (bit_q == BITS_BYTE) begin
              wr_q     <= 1'b1;
              wa_q     <= ptr_q;
              wd_q     <= sh_q;
              ptr_q    <= ptr_q + 8'h01;
              sda_oe_q <= 1'b1;
              st_q     <= ST_WACK;
            end
          end
          ST_RDAT: begin
            if (bit_q == BITS_BYTE) begin
              sda_oe_q <= 1'b0;
              st_q     <= ST_MACK;
            end else begin
              sda_oe_q <= ~sh_q[6];
              sh_q     <= {sh_q[6:0], 1'b0};
              bit_q    <= bit_q + 4'h1;
            end
          end
          ST_MACK: begin
            sh_q     <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
            bit_q    <= 4'h1;
            st_q     <= ST_RDAT;
          end
          ST_IDLE: begin
          end
        endcase
      end
    end
  end
  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;

  // Write masks per group
  logic [23:0] wd3;
  logic [23:0] m_set;
  logic [23:0] m_clr;
  logic [23:0] m_edge;
  logic [23:0] ev;
  assign wd3    = {3{wd_q}};
  assign m_set  = wr_q ? lane(wa_q, OFS_SET) : RST_ZERO;
  assign m_clr  = wr_q ? lane(wa_q, OFS_CLR) : RST_ZERO;
  assign m_edge = wr_q ? lane(wa_q, OFS_EDGE) : RST_ZERO;
  assign ev     = (pin_if.rise & rise_q) | (pin_if.fall & fall_q);

  // Output level, held whatever the direction
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lvl_q <= RST_ZERO;
    end else begin
      lvl_q <= (lvl_q | (m_set & wd3)) & ~(m_clr & wd3);
    end
  end

  // Edge status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      edge_q <= RST_ZERO;
    end else begin
      edge_q <= (edge_q & ~(m_edge & wd3)) | ev;
    end
  end

  // Plain read/write configuration groups
  function automatic logic [23:0] upd(input logic [23:0] v, input logic [7:0] base);
    logic [23:0] m;
    m = wr_q ? lane(wa_q, base) : RST_ZERO;
    return (v & ~m) | (wd3 & m);
  endfunction : upd

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dir_q  <= RST_ZERO;
      rise_q <= RST_ZERO;
      fall_q <= RST_ZERO;
      pu_q   <= RST_ZERO;
      pd_q   <= RST_ZERO;
      afu_q  <= RST_ZERO;
      afl_q  <= RST_ZERO;
    end else begin
      dir_q  <= upd(dir_q, OFS_DIR);
      rise_q <= upd(rise_q, OFS_RISE);
      fall_q <= upd(fall_q, OFS_FALL);
      pu_q   <= upd(pu_q, OFS_PU);
      pd_q   <= upd(pd_q, OFS_PD);
      afu_q  <= upd(afu_q, OFS_AFU);
      afl_q  <= upd(afl_q, OFS_AFL);
    end
  end

  // Pin p field sits at bits 2p+1:2p of the joined selector word
  assign func_sel    = {afu_q, afl_q};
  assign pullup_en   = pu_q;
  assign pulldown_en = pd_q;
  assign edge_status = edge_q;

  genvar i;
  generate
    for (i = 0; i < NPIN; i++) begin : g_route
      logic [1:0] fn;
      logic [1:0] alt;
      assign fn  = func_sel[2*i+:2];
      assign alt = fn - 2'h1;
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          gpio_o[i]  <= 1'b0;
          gpio_oe[i] <= 1'b0;
        end else if (fn == FN_PRIMARY) begin
          gpio_o[i]  <= lvl_q[i];
          gpio_oe[i] <= dir_q[i];
        end else begin
          gpio_o[i]  <= alt_o[alt][i];
          gpio_oe[i] <= alt_oe[alt][i];
        end
      end
    end
  endgenerate

  a_set_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_q && wa_q == OFS_SET + 8'h02 |=> (lvl_q[7:0] & $past(wd_q)) == $past(wd_q))
    else $error("set byte did not raise level");
  a_set_keeps: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_q && wa_q == OFS_SET + 8'h02 |=> (lvl_q[7:0] & ~$past(wd_q)) == ($past(lvl_q[7:0]) & ~$past(wd_q)))
    else $error("set byte disturbed zero bits");
  a_clr_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_q && wa_q == OFS_CLR |=> (lvl_q[23:16] & $past(wd_q)) == 8'h00)
    else $error("clear byte did not lower level");
  a_mon_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ptr_q == OFS_MON + 8'h01 |-> rd_byte == pin_if.lvl[15:8])
    else $error("monitor byte does not show pins");
  a_edge_rise: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pin_if.rise[5] && rise_q[5] |=> edge_q[5])
    else $error("enabled rising edge not recorded");
  a_edge_fall: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pin_if.fall[20] && fall_q[20] |=> edge_q[20])
    else $error("enabled falling edge not recorded");
  a_edge_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_q && wa_q == OFS_EDGE + 8'h02 && wd_q[0] && !ev[0] |=> !edge_q[0])
    else $error("edge status not cleared by one");
  a_edge_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !edge_q[3] && !ev[3] |=> !edge_q[3])
    else $error("edge status set without event");
  a_dir_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
    func_sel[1:0] == FN_PRIMARY |=> gpio_oe[0] == $past(dir_q[0]) && gpio_o[0] == $past(lvl_q[0]))
    else $error("primary pin not driven from registers");
  a_pull_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_q && (wa_q == OFS_PU || wa_q == OFS_PD)
    |=> $past(wd_q) == (($past(wa_q) == OFS_PU) ? pullup_en[23:16] : pulldown_en[23:16]))
    else $error("pull control did not take written byte");
  a_func_upper: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_q && wa_q == OFS_AFU + 8'h02 |=> func_sel[31:24] == $past(wd_q))
    else $error("upper selector low byte misplaced");
  a_func_lower: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_q && wa_q == OFS_AFL |=> func_sel[23:16] == $past(wd_q))
    else $error("lower selector high byte misplaced");
  a_alt_route: assert property (@(posedge clk_sys) disable iff (!rst_b)
    func_sel[5:4] == 2'h2 |=> gpio_o[2] == $past(alt_o[1][2]))
    else $error("alternate two not routed");

  c_reg_write: cover property (@(posedge clk_sys) disable iff (!rst_b) wr_q);
  c_reg_read:  cover property (@(posedge clk_sys) disable iff (!rst_b) st_q == ST_MACK && scl_rise && !sda_q);
  c_edge_set:  cover property (@(posedge clk_sys) disable iff (!rst_b) |ev);
  c_alt_sel:   cover property (@(posedge clk_sys) disable iff (!rst_b) func_sel[47:46] == 2'h3);
endmodule : gpb_top

// ===== sim/gpb_i2c_host.sv
// Behavioural serial bus host that reaches the pin bank registers
`timescale 1ns/1ps
module gpb_i2c_host
  import gpb_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_low,
  output logic            rd_valid,
  output logic      [7:0] rd_data
);
  int nacks = 0;

  initial begin
    scl      = 1'b1;
    sda_low  = 1'b0;
    rd_valid = 1'b0;
    rd_data  = 8'h00;
  end

  task automatic ph();
    repeat (40) @(negedge clk_sys);
  endtask : ph

  // Data moves only well after the clock fall so it is never read as a start or stop
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    ph();
    scl = 1'b1;
    ph();
    s = sda;
    scl = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : bit_io

  task automatic start();
    sda_low = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b1;
    ph();
    scl = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : start

  task automatic stop();
    sda_low = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b0;
    ph();
  endtask : stop

  task automatic wbyte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    if (s !== 1'b0) begin
      nacks++;
    end
  endtask : wbyte

  task automatic rbyte(input logic ack);
    logic [7:0] d;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!ack, s);
    rd_data  = d;
    rd_valid = 1'b1;
    @(negedge clk_sys);
    rd_valid = 1'b0;
  endtask : rbyte

  // Three bytes of one group, high byte first, pointer auto-increments
  task automatic wr3(input logic [7:0] a, input logic [23:0] d);
    start();
    wbyte({DEV_ADDR, 1'b0});
    wbyte(a);
    wbyte(d[23:16]);
    wbyte(d[15:8]);
    wbyte(d[7:0]);
    stop();
  endtask : wr3

  task automatic rd3(input logic [7:0] a);
    start();
    wbyte({DEV_ADDR, 1'b0});
    wbyte(a);
    start();
    wbyte({DEV_ADDR, 1'b1});
    rbyte(1'b1);
    rbyte(1'b1);
    rbyte(1'b0);
    stop();
  endtask : rd3
endmodule : gpb_i2c_host

// ===== sim/gpio_pin_control_bank_tb.sv
// Self-checking bench for the GPIO pin control bank
`timescale 1ns/1ps
module gpio_pin_control_bank_tb;
  import gpb_pkg::*;
  logic             clk_sys     = 1'b0;
  logic             rst_b       = 1'b0;
  logic      [23:0] gpio_i      = 24'h000000;
  logic [2:0][23:0] alt_o       = '0;
  logic [2:0][23:0] alt_oe      = '0;
  logic             scl;
  logic             sda_low;
  logic             sda_o;
  logic             sda_oe;
  logic             rd_valid;
  logic       [7:0] rd_data;
  logic      [23:0] gpio_o;
  logic      [23:0] gpio_oe;
  logic      [23:0] pullup_en;
  logic      [23:0] pulldown_en;
  logic      [23:0] edge_status;
  logic      [47:0] func_sel;
  logic       [7:0] expq[$];
  int               n_errors    = 0;
  int               comparisons = 0;
  // Open-drain data line with pull-up
  wire              sda         = sda_oe ? sda_o : !sda_low;

  always #2.5 clk_sys = !clk_sys;

  gpb_top i_gpb_top (.clk_sys(clk_sys), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .pullup_en(pullup_en),
    .pulldown_en(pulldown_en), .func_sel(func_sel), .edge_status(edge_status), .alt_o(alt_o),
    .alt_oe(alt_oe));

  gpb_i2c_host i_gpb_i2c_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low),
    .rd_valid(rd_valid), .rd_data(rd_data));

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    i_gpb_i2c_host.wr3(a, d);
  endtask : wr

  task automatic rd_exp(input logic [7:0] a, input logic [23:0] d);
    expq.push_back(d[23:16]);
    expq.push_back(d[15:8]);
    expq.push_back(d[7:0]);
    i_gpb_i2c_host.rd3(a);
  endtask : rd_exp

  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      check("read byte", {16'h0000, rd_data}, {16'h0000, expq.pop_front()});
    end
  end

  initial begin
    #480000;
    n_errors++;
    give_verdict();
  end

  initial begin
    logic [23:0] v[5];
    logic [7:0]  ofs[5];
    logic [23:0] s, c, g, e, lv, eo, ee;
    logic [47:0] fs;
    logic [1:0]  f;
    ofs = '{OFS_DIR, OFS_PU, OFS_PD, OFS_RISE, OFS_FALL};
    void'($urandom(32'h1C0984CB));
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    for (int k = 0; k < 3; k++) begin
      alt_o[k]  = 24'($urandom);
      alt_oe[k] = 24'($urandom);
    end
    repeat (8) @(negedge clk_sys);
    check("func_sel", func_sel[23:0], RST_ZERO);
    check("gpio_oe", gpio_oe, RST_ZERO);
    rd_exp(OFS_AFL, RST_ZERO);
    for (int k = 0; k < 5; k++) begin
      v[k] = 24'($urandom);
      wr(ofs[k], v[k]);
      if (k > 2) begin
        rd_exp(ofs[k], v[k]);
      end
    end
    check("gpio_oe", gpio_oe, v[0]);
    check("pullup_en", pullup_en, v[1]);
    check("pulldown_en", pulldown_en, v[2]);
    s = 24'($urandom);
    c = 24'($urandom);
    wr(OFS_DIR, RST_ZERO);
    wr(OFS_SET, s);
    check("gpio_oe", gpio_oe, RST_ZERO);
    wr(OFS_DIR, 24'hFFFFFF);
    check("gpio_o", gpio_o, s);
    wr(OFS_CLR, c);
    lv = s & ~c;
    check("gpio_o", gpio_o, lv);
    rd_exp(OFS_SET, RST_ZERO);
    // Edges: rise on the way up, fall on the way down
    g = 24'($urandom);
    gpio_i = g;
    repeat (10) @(negedge clk_sys);
    e = g & v[3];
    check("edge_status", edge_status, e);
    wr(OFS_MON, ~g);
    rd_exp(OFS_MON, g);
    gpio_i = RST_ZERO;
    repeat (10) @(negedge clk_sys);
    e = e | (g & v[4]);
    rd_exp(OFS_EDGE, e);
    c = 24'($urandom);
    wr(OFS_EDGE, c);
    check("edge_status", edge_status, e & ~c);
    // Low pins cycle through all four selector codes
    fs = {24'($urandom), 24'hE4E4E4};
    wr(OFS_AFU, fs[47:24]);
    wr(OFS_AFL, fs[23:0]);
    check("func_sel", func_sel[47:24], fs[47:24]);
    check("func_sel", func_sel[23:0], fs[23:0]);
    for (int p = 0; p < 24; p++) begin
      f = fs[2*p+:2];
      eo[p] = (f == FN_PRIMARY) ? lv[p] : alt_o[f-2'h1][p];
      ee[p] = (f == FN_PRIMARY) ? 1'b1 : alt_oe[f-2'h1][p];
    end
    check("gpio_o", gpio_o, eo);
    check("gpio_oe", gpio_oe, ee);
    // A foreign address is left unanswered and the next transfer still works
    i_gpb_i2c_host.start();
    i_gpb_i2c_host.wbyte({~DEV_ADDR, 1'b0});
    i_gpb_i2c_host.stop();
    rd_exp(OFS_AFU, fs[47:24]);
    check("acks", 24'(i_gpb_i2c_host.nacks), 24'h000001);
    give_verdict();
  end
endmodule : gpio_pin_control_bank_tb
